// ### hdl/osc_pkg.sv
package osc_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIM = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;

  // control register fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_SRC_W = 2;
  localparam int CTRL_FSEL_LSB = 3;
  localparam int CTRL_FSEL_W = 4;
  localparam logic [3:0] CTRL_FSEL_RST = 4'h7;
  localparam logic [1:0] CTRL_SRC_RST = 2'h0;

  // trim register, two's complement
  localparam int TRIM_W = 6;
  localparam logic [5:0] TRIM_RST = 6'h00;

  // frequency select decoding
  localparam logic [2:0] FSEL_LF_TOP = 3'h0;
  localparam logic [3:0] FSEL_HF_MIN = 4'hb;
  localparam logic [2:0] CFG_OSC_INTERNAL = 3'h4;

  // state register and irq bit positions share this layout
  localparam int FLAGS_W = 5;

  // timing, ns and kHz as figures, cycles derived
  localparam int CLK_KHZ = 100000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BASE_KHZ = 500;
  localparam int LF_KHZ = 31;
  localparam int BASE_DIV = CLK_KHZ / BASE_KHZ;
  localparam int LF_DIV = CLK_KHZ / LF_KHZ;
  localparam int HF_READY_NS = 5000;
  localparam int HF_LOCK_NS = 20000;
  localparam int HF_STABLE_NS = 60000;
  localparam int MF_READY_NS = 5000;
  localparam int LF_READY_NS = 10000;
  localparam int FAST_START_NS = 2000;
  localparam int TRIM_STEP_NS = 1000;
  localparam int HF_READY_CYC = (HF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HF_LOCK_CYC = (HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HF_STABLE_CYC = (HF_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MF_READY_CYC = (MF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LF_READY_CYC = (LF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_START_CYC = (FAST_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIM_STEP_CYC = (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic hf_ready_flag;
    logic hf_locked_flag;
    logic mf_ready_flag;
    logic lf_ready_flag;
    logic hf_stable_flag;
  } osc_flags_s;

  typedef struct packed {
    logic [3:0] freq_select_field;
    logic [1:0] sysclk_source_select;
  } osc_ctrl_s;

  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_HF = 2'h1,
    SRC_MF = 2'h3,
    SRC_LF = 2'h2
  } osc_src_e;

  function automatic logic is_lf_code(input logic [3:0] fsel);
    return fsel[3:1] == FSEL_LF_TOP;
  endfunction

  function automatic logic is_hf_code(input logic [3:0] fsel);
    return fsel >= FSEL_HF_MIN;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic run);
    if (!run)
      return 16'h0000;
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

endpackage

// ### hdl/osc_intosc_ctl.sv
// Contract
// - provide a 16 MHz high-frequency source whose frequency follows the trim register
// - four-bit frequency select field picks one postscaled derived frequency
// - enable high-freq source on HF select and internal config or source select 1x
// - fast startup oscillator runs first; switch to high-freq source once it is ready
// - high-freq ready flag set while high-freq source runs
// - high-freq locked flag set once within 2% of final frequency
// - high-freq stable flag set once within 0.5% of final frequency
// - provide 500 kHz medium-frequency source, nine derived frequencies via select field
// - medium-freq ready flag set while medium-freq source runs
// - both high and medium sources come from the trimmed 500 kHz base
// - trim is 6-bit two's complement, reset zero, 1fh fastest, 20h slowest
// - trim change slews gradually while code runs; no completion flag exists
// - trim never touches the low-freq source or its timer users
// - provide untrimmed 31 kHz low-freq source selectable as system clock
// - low-freq source clocks power-up timer, watchdog and clock-fail monitor
// - enable low-freq source on LF select with 1x, or any user peripheral on
// - low-freq ready flag set while low-freq source runs
//
// The APB register port and the register offsets were chosen for this implementation.
module osc_intosc_ctl #(
  parameter int HF_READY_CYC = osc_pkg::HF_READY_CYC,
  parameter int HF_LOCK_CYC = osc_pkg::HF_LOCK_CYC,
  parameter int HF_STABLE_CYC = osc_pkg::HF_STABLE_CYC,
  parameter int MF_READY_CYC = osc_pkg::MF_READY_CYC,
  parameter int LF_READY_CYC = osc_pkg::LF_READY_CYC,
  parameter int FAST_START_CYC = osc_pkg::FAST_START_CYC,
  parameter int TRIM_STEP_CYC = osc_pkg::TRIM_STEP_CYC,
  parameter int BASE_DIV = osc_pkg::BASE_DIV,
  parameter int LF_DIV = osc_pkg::LF_DIV
) (
  input wire logic pclk, // bus and core clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [2:0] config_osc_select, // configuration oscillator select
  input wire logic powerup_delay_timer_en, // power-up timer wants low-freq clock
  input wire logic watchdog_counter_en, // watchdog wants low-freq clock
  input wire logic clock_fail_monitor_en, // clock-fail monitor wants low-freq clock
  output logic high_freq_osc_en, // high-freq oscillator enable
  output logic mid_freq_osc_en, // medium-freq oscillator enable
  output logic low_freq_osc_en, // low-freq oscillator enable
  output logic [5:0] trim_applied, // trim value currently driving the base
  output logic base_tick, // one-cycle pulse at trimmed 500 kHz rate
  output logic low_freq_tick, // one-cycle pulse at untrimmed 31 kHz rate
  output logic [3:0] postscale_sel, // derived frequency handed to the postscaler
  output osc_pkg::osc_src_e sysclk_src, // oscillator now feeding the system clock
  output logic irq // level interrupt
);

  // bus decode
  wire logic acc = psel && penable;
  wire logic commit = acc && pready;
  wire logic wr_commit = commit && pwrite;
  wire logic hit_ctrl = paddr == osc_pkg::ADDR_CTRL;
  wire logic hit_trim = paddr == osc_pkg::ADDR_TRIM;
  wire logic hit_state = paddr == osc_pkg::ADDR_STATE;
  wire logic hit_stat = paddr == osc_pkg::ADDR_IRQ_STAT;
  wire logic hit_en = paddr == osc_pkg::ADDR_IRQ_EN;
  wire logic hit_clr = paddr == osc_pkg::ADDR_IRQ_CLR;
  wire logic mapped = hit_ctrl | hit_trim | hit_state | hit_stat | hit_en | hit_clr;

  osc_pkg::osc_ctrl_s ctrl_q;
  logic [5:0] trim_tgt_q;
  logic [5:0] trim_cur_q;
  logic [15:0] trim_tmr_q;
  logic [4:0] irq_stat_q;
  logic [4:0] irq_en_q;
  osc_pkg::osc_flags_s flags_q;
  osc_pkg::osc_flags_s flags_d;
  logic [15:0] hf_cnt_q;
  logic [15:0] mf_cnt_q;
  logic [15:0] lf_cnt_q;
  logic [15:0] fast_cnt_q;
  logic [15:0] base_div_q;
  logic [15:0] lf_div_q;
  osc_pkg::osc_src_e src_q;
  osc_pkg::osc_src_e src_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // enables
  wire logic fsel_lf = osc_pkg::is_lf_code(ctrl_q.freq_select_field);
  wire logic fsel_hf = osc_pkg::is_hf_code(ctrl_q.freq_select_field);
  wire logic fsel_mf = !fsel_lf && !fsel_hf;
  wire logic intosc_sel = (config_osc_select == osc_pkg::CFG_OSC_INTERNAL)
                          || ctrl_q.sysclk_source_select[1];
  wire logic hf_en = fsel_hf && intosc_sel;
  wire logic mf_en = fsel_mf && intosc_sel;
  wire logic lf_users = powerup_delay_timer_en || watchdog_counter_en
                        || clock_fail_monitor_en;
  wire logic lf_en = (fsel_lf && intosc_sel) || lf_users;
  // base runs whenever either derived source needs it
  wire logic base_en = hf_en || mf_en;

  // flags follow their oscillators; state register writes are not decoded
  always_comb
  begin
    flags_d.hf_ready_flag = hf_en && (hf_cnt_q >= 16'(HF_READY_CYC));
    flags_d.hf_locked_flag = hf_en && (hf_cnt_q >= 16'(HF_LOCK_CYC));
    flags_d.hf_stable_flag = hf_en && (hf_cnt_q >= 16'(HF_STABLE_CYC));
    flags_d.mf_ready_flag = mf_en && (mf_cnt_q >= 16'(MF_READY_CYC));
    flags_d.lf_ready_flag = lf_en && (lf_cnt_q >= 16'(LF_READY_CYC));
  end

  // irq events are rising edges of the state flags; set beats clear
  wire logic [4:0] flag_rise = flags_d & ~flags_q;
  wire logic [4:0] clr_mask = (wr_commit && hit_clr) ? pwdata[4:0] : 5'h00;
  wire logic [4:0] irq_stat_d = (irq_stat_q & ~clr_mask) | flag_rise;

  // fast startup source holds the system clock until its start interval ends and the chosen source is ready
  wire logic fast_done = fast_cnt_q >= 16'(FAST_START_CYC);
  always_comb
  begin
    src_d = src_q;
    if (fast_done)
    begin
      if (hf_en && flags_q.hf_ready_flag)
        src_d = osc_pkg::SRC_HF;
      else if (mf_en && flags_q.mf_ready_flag)
        src_d = osc_pkg::SRC_MF;
      else if (fsel_lf && intosc_sel && flags_q.lf_ready_flag)
        src_d = osc_pkg::SRC_LF;
    end
  end

  // trim slews one lsb per step interval toward the written target
  wire logic trim_step = trim_tmr_q >= 16'(TRIM_STEP_CYC - 1);
  wire logic trim_up = $signed(trim_tgt_q) > $signed(trim_cur_q);
  wire logic trim_dn = $signed(trim_tgt_q) < $signed(trim_cur_q);
  wire logic [5:0] trim_next = trim_up ? trim_cur_q + 6'h01 : trim_cur_q - 6'h01;
  // higher trim shortens the base period: 1fh fastest, 20h slowest
  wire logic [15:0] base_reload = 16'(BASE_DIV - 1) - {{10{trim_cur_q[5]}}, trim_cur_q};
  wire logic base_wrap = base_div_q == 16'h0000;
  wire logic lf_wrap = lf_div_q == 16'h0000;

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      hit_ctrl:
        rd_mux[osc_pkg::CTRL_FSEL_LSB +: osc_pkg::CTRL_FSEL_W] = ctrl_q.freq_select_field;
      hit_trim:
        rd_mux[osc_pkg::TRIM_W-1:0] = trim_tgt_q;
      hit_state:
        rd_mux[osc_pkg::FLAGS_W-1:0] = flags_q;
      hit_stat:
        rd_mux[osc_pkg::FLAGS_W-1:0] = irq_stat_q;
      hit_en:
        rd_mux[osc_pkg::FLAGS_W-1:0] = irq_en_q;
      default:
        rd_mux = 32'h0000_0000;
    endcase
    if (hit_ctrl)
      rd_mux[osc_pkg::CTRL_SRC_LSB +: osc_pkg::CTRL_SRC_W] = ctrl_q.sysclk_source_select;
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !mapped;
      prdata_q <= (acc && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q.freq_select_field <= osc_pkg::CTRL_FSEL_RST;
      ctrl_q.sysclk_source_select <= osc_pkg::CTRL_SRC_RST;
    end
    else if (wr_commit && hit_ctrl)
    begin
      ctrl_q.freq_select_field <= pwdata[osc_pkg::CTRL_FSEL_LSB +: osc_pkg::CTRL_FSEL_W];
      ctrl_q.sysclk_source_select <= pwdata[osc_pkg::CTRL_SRC_LSB +: osc_pkg::CTRL_SRC_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trim_tgt_q <= osc_pkg::TRIM_RST;
    else if (wr_commit && hit_trim)
      trim_tgt_q <= pwdata[osc_pkg::TRIM_W-1:0];
  end

  // no flag reports the end of a slew, software just sees the new target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_cur_q <= osc_pkg::TRIM_RST;
      trim_tmr_q <= 16'h0000;
    end
    else
    begin
      trim_tmr_q <= (trim_step || !(trim_up || trim_dn)) ? 16'h0000 : trim_tmr_q + 16'h0001;
      if (trim_step && (trim_up || trim_dn))
        trim_cur_q <= trim_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= 5'h00;
      irq_en_q <= 5'h00;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      if (wr_commit && hit_en)
        irq_en_q <= pwdata[osc_pkg::FLAGS_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hf_cnt_q <= 16'h0000;
      mf_cnt_q <= 16'h0000;
      lf_cnt_q <= 16'h0000;
      fast_cnt_q <= 16'h0000;
      flags_q <= '0;
    end
    else
    begin
      hf_cnt_q <= osc_pkg::sat_inc(hf_cnt_q, hf_en);
      mf_cnt_q <= osc_pkg::sat_inc(mf_cnt_q, mf_en);
      lf_cnt_q <= osc_pkg::sat_inc(lf_cnt_q, lf_en);
      fast_cnt_q <= osc_pkg::sat_inc(fast_cnt_q, 1'b1);
      flags_q <= flags_d;
    end
  end

  // falls back to the fast source only on reset; a dead oscillator is the monitor's job
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_q <= osc_pkg::SRC_FAST;
    else
      src_q <= src_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      base_div_q <= 16'h0000;
    else if (!base_en || base_wrap)
      base_div_q <= base_reload;
    else
      base_div_q <= base_div_q - 16'h0001;
  end

  // low-freq divider never sees the trim value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lf_div_q <= 16'h0000;
    else if (!lf_en || lf_wrap)
      lf_div_q <= 16'(LF_DIV - 1);
    else
      lf_div_q <= lf_div_q - 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_freq_osc_en <= 1'b0;
      mid_freq_osc_en <= 1'b0;
      low_freq_osc_en <= 1'b0;
      trim_applied <= osc_pkg::TRIM_RST;
      base_tick <= 1'b0;
      low_freq_tick <= 1'b0;
      postscale_sel <= osc_pkg::CTRL_FSEL_RST;
      irq <= 1'b0;
    end
    else
    begin
      high_freq_osc_en <= hf_en;
      mid_freq_osc_en <= mf_en;
      low_freq_osc_en <= lf_en;
      trim_applied <= trim_cur_q;
      base_tick <= base_en && base_wrap;
      low_freq_tick <= lf_en && lf_wrap;
      postscale_sel <= ctrl_q.freq_select_field;
      irq <= |(irq_stat_d & irq_en_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sysclk_src = src_q;

endmodule // osc_intosc_ctl

// ### dv/osc_intosc_ctl_sva.sv
module osc_intosc_ctl_chk #(
  parameter int BASE_DIV = 200,
  parameter int LF_DIV = 3225
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [2:0] config_osc_select, // config
  input wire logic powerup_delay_timer_en, // lf user
  input wire logic watchdog_counter_en, // lf user
  input wire logic clock_fail_monitor_en, // lf user
  input wire logic high_freq_osc_en, // enable
  input wire logic mid_freq_osc_en, // enable
  input wire logic low_freq_osc_en, // enable
  input wire logic [5:0] trim_applied, // trim
  input wire logic base_tick, // tick
  input wire logic low_freq_tick, // tick
  input wire logic [3:0] postscale_sel // select
);
  logic [15:0] lgap_q, bgap_q;
  logic lseen_q, bseen_q;
  logic [5:0] btrim_q;
  // gaps only judged over an unbroken run, a restart may phase-shift the tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lgap_q <= 16'h0000;
      bgap_q <= 16'h0000;
      lseen_q <= 1'b0;
      bseen_q <= 1'b0;
      btrim_q <= 6'h00;
    end
    else
    begin
      lgap_q <= low_freq_tick ? 16'h0000 : lgap_q + 16'h0001;
      bgap_q <= base_tick ? 16'h0000 : bgap_q + 16'h0001;
      lseen_q <= low_freq_tick || (lseen_q && low_freq_osc_en);
      bseen_q <= base_tick || (bseen_q && (high_freq_osc_en || mid_freq_osc_en));
      btrim_q <= base_tick ? trim_applied : btrim_q;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_first_access;
    psel && penable && !$past(penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 (pready && psel && penable);
  endsequence
  a_pready_wait: assert property (s_first_access |-> s_one_wait)
    else $error("pready not after one wait state");
  a_slverr_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
    else $error("pslverr does not follow address map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_hf_code_off: assert property (postscale_sel < 4'hb |-> !high_freq_osc_en)
    else $error("hf enabled without hf code");
  a_hf_cfg_on: assert property (
    $past(presetn) && postscale_sel >= 4'hb && $past(config_osc_select) == 3'h4
    |-> high_freq_osc_en) else $error("hf not enabled by config");
  a_mf_cfg_on: assert property (
    $past(presetn) && postscale_sel[3:1] != 3'h0 && postscale_sel < 4'hb
    && $past(config_osc_select) == 3'h4 |-> mid_freq_osc_en) else $error("mf not enabled");
  a_lf_users_on: assert property (
    (powerup_delay_timer_en || watchdog_counter_en || clock_fail_monitor_en)
    |=> low_freq_osc_en) else $error("lf not enabled by user");
  a_lf_period: assert property (low_freq_tick && lseen_q |-> lgap_q == 16'(LF_DIV - 1))
    else $error("lf tick period wrong");
  a_base_period: assert property (
    base_tick && bseen_q && trim_applied == btrim_q
    |-> int'(bgap_q) == BASE_DIV - 1 - int'($signed(trim_applied)))
    else $error("base tick period wrong");
  a_trim_step: assert property (
    trim_applied != $past(trim_applied)
    |-> 6'(trim_applied - $past(trim_applied)) inside {6'h01, 6'h3f})
    else $error("trim jumped more than one step");
endmodule // osc_intosc_ctl_chk

bind osc_intosc_ctl osc_intosc_ctl_chk #(.BASE_DIV(BASE_DIV), .LF_DIV(LF_DIV)) i_chk (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr, .config_osc_select,
  .powerup_delay_timer_en, .watchdog_counter_en, .clock_fail_monitor_en, .high_freq_osc_en,
  .mid_freq_osc_en, .low_freq_osc_en, .trim_applied, .base_tick, .low_freq_tick, .postscale_sel);

// ### dv/test_osc_intosc_ctl.sv
module test_osc_intosc_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, base_tick, low_freq_tick;
  logic powerup_delay_timer_en, watchdog_counter_en, clock_fail_monitor_en;
  logic high_freq_osc_en, mid_freq_osc_en, low_freq_osc_en, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] config_osc_select;
  logic [5:0] trim_applied;
  logic [3:0] postscale_sel;
  osc_pkg::osc_src_e sysclk_src;
  int mismatches, compares, cyc;

  // trim step, fast start, low-freq ready and base divider keep their real defaults
  osc_intosc_ctl #(.HF_READY_CYC(5), .HF_LOCK_CYC(10), .HF_STABLE_CYC(20), .MF_READY_CYC(5),
    .LF_DIV(40))
  i_osc_intosc_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .config_osc_select, .powerup_delay_timer_en, .watchdog_counter_en,
    .clock_fail_monitor_en, .high_freq_osc_en, .mid_freq_osc_en, .low_freq_osc_en,
    .trim_applied, .base_tick, .low_freq_tick, .postscale_sel, .sysclk_src, .irq);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request stays up until the edge that samples pready; the answer is taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      @(posedge pclk);
    end
    chk("wait_states", n, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, rd, e);
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_reset();
    @(negedge pclk);
    chk("src_rst", sysclk_src, osc_pkg::SRC_FAST);
    rchk("ctrl_rst", osc_pkg::ADDR_CTRL, 32'h38);
    rchk("trim_rst", osc_pkg::ADDR_TRIM, 32'h0);
    apb(1'b1, osc_pkg::ADDR_STATE, 32'h1f);
    rchk("state_ro", osc_pkg::ADDR_STATE, 32'h0);
    rchk("clr_rd", osc_pkg::ADDR_IRQ_CLR, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
  endtask

  task automatic t_mf();
    apb(1'b1, osc_pkg::ADDR_CTRL, 32'h3a);
    repeat (20) @(posedge pclk);
    rchk("state_mf", osc_pkg::ADDR_STATE, 32'h04);
    rchk("irq_stat", osc_pkg::ADDR_IRQ_STAT, 32'h04);
    @(negedge pclk);
    chk("irq_masked", irq, 1'b0);
    chk("src_fast_hold", sysclk_src, osc_pkg::SRC_FAST);
    repeat (osc_pkg::FAST_START_CYC) @(posedge pclk);
    settle();
    chk("src_mf", sysclk_src, osc_pkg::SRC_MF);
    chk("mf_en", mid_freq_osc_en, 1'b1);
    apb(1'b1, osc_pkg::ADDR_IRQ_EN, 32'h1f);
    settle();
    chk("irq_on", irq, 1'b1);
    apb(1'b1, osc_pkg::ADDR_IRQ_CLR, 32'h04);
    settle();
    chk("irq_clr", irq, 1'b0);
    rchk("stat_clr", osc_pkg::ADDR_IRQ_STAT, 32'h0);
  endtask

  task automatic t_trim();
    apb(1'b1, osc_pkg::ADDR_TRIM, 32'hffffffff);
    rchk("trim_wide", osc_pkg::ADDR_TRIM, 32'h3f);
    apb(1'b1, osc_pkg::ADDR_TRIM, 32'h1f);
    rchk("trim_max", osc_pkg::ADDR_TRIM, 32'h1f);
    settle();
    chk("trim_slewing", trim_applied, 6'h00);
    repeat (33 * osc_pkg::TRIM_STEP_CYC) @(posedge pclk);
    settle();
    chk("trim_hi", trim_applied, 6'h1f);
    apb(1'b1, osc_pkg::ADDR_TRIM, 32'h20);
    repeat (64 * osc_pkg::TRIM_STEP_CYC) @(posedge pclk);
    settle();
    chk("trim_lo", trim_applied, 6'h20);
  endtask

  task automatic t_hf();
    apb(1'b1, osc_pkg::ADDR_CTRL, 32'h7a);
    repeat (14) @(posedge pclk);
    rchk("hf_lock", osc_pkg::ADDR_STATE, 32'h18);
    repeat (10) @(posedge pclk);
    rchk("hf_stable", osc_pkg::ADDR_STATE, 32'h19);
    settle();
    chk("src_hf", sysclk_src, osc_pkg::SRC_HF);
    chk("postscale", postscale_sel, 4'hf);
    @(posedge pclk);
    config_osc_select <= 3'h4;
    apb(1'b1, osc_pkg::ADDR_CTRL, 32'h78);
    settle();
    chk("hf_cfg", high_freq_osc_en, 1'b1);
    apb(1'b1, osc_pkg::ADDR_CTRL, 32'h38);
    settle();
    chk("mf_cfg", {high_freq_osc_en, mid_freq_osc_en}, 2'b01);
    @(posedge pclk);
    config_osc_select <= 3'h0;
    settle();
    rchk("flags_off", osc_pkg::ADDR_STATE, 32'h0);
  endtask

  task automatic t_lf();
    apb(1'b1, osc_pkg::ADDR_CTRL, 32'h02);
    repeat (osc_pkg::LF_READY_CYC) @(posedge pclk);
    rchk("lf_ready", osc_pkg::ADDR_STATE, 32'h02);
    settle();
    chk("src_lf", sysclk_src, osc_pkg::SRC_LF);
    apb(1'b1, osc_pkg::ADDR_CTRL, 32'h38);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      {powerup_delay_timer_en, watchdog_counter_en, clock_fail_monitor_en} <= 3'b001 << i;
      repeat (100) @(posedge pclk);
      settle();
      chk("lf_user", low_freq_osc_en, 1'b1);
    end
    @(posedge pclk);
    {powerup_delay_timer_en, watchdog_counter_en, clock_fail_monitor_en} <= 3'b000;
    settle();
    chk("lf_off", low_freq_osc_en, 1'b0);
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    // two full trim slews and the low-freq ready wait dominate, about 12k cycles
    if (cyc == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {config_osc_select, powerup_delay_timer_en, watchdog_counter_en} = '0;
    clock_fail_monitor_en = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mf();
    t_trim();
    t_hf();
    t_lf();
    report_and_stop();
  end
endmodule // test_osc_intosc_ctl
